// ---- verilog/stream_entry_stall_ats_check.sv ----
// Stream entry decode and policy check for stall disable and ATS enable fields.
// Assumes entry, capabilities and requests come from host logic on core_clk;
// a register master reaches control, status and mask over AXI4-Lite.
//
// Functional notes
// - No stage 1: partition IDs from entry.
// - Stall disable forbids stage 1 stall model.
// - Without stage 1, stall disable reads zero.
// - Stage 1 disabled: ignore stall disable.
// - Stall disable set, model fixed: illegal.
// - ATS field governs requests and translated traffic.
// - ATS off: UR plus bad-request event.
// - ATS off, checking: abort, forbidden event.
// - Full ATS: translate all, translated bypasses.
// - Newer mode: full ATS, config1, stall2 illegal.
// - Older mode: full ATS, stall2 illegal if strict or config1.
// - Split ATS: stage1 answer, stage2 later.
// - Split ATS illegal unless nested, capable; code also makes it illegal with stall2 selected.
// - Split ATS without checking acts as off.
// - Reserved ATS encoding acts as off.
// - Translated checked only when check bit set.
// - No ATS support: field ignored, nothing passes.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module stream_entry_stall_ats_check
  import stream_check_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire xact_kind_t reqKind,
  input wire entry_t entry,
  input wire caps_t caps,
  output verdict_t verdict,
  output logic verdictValid,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Known register offset test
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == CTRL_OFF) || (addr == STATUS_OFF) ||
      (addr == MASK_OFF) || (addr == LAST_OFF);
  endfunction

  logic [2:0] ctrl_r;
  logic [EVT_W-1:0] status_r;
  logic [EVT_W-1:0] mask_r;
  logic checkBit;
  logic v31Mode;
  logic v30Strict;
  logic writeFire;
  logic readFire;
  logic [7:0] wAddr;

  assign checkBit = ctrl_r[CTRL_CHECK_BIT];
  assign v31Mode = ctrl_r[CTRL_V31_BIT];
  assign v30Strict = ctrl_r[CTRL_V30_STRICT_BIT];
  assign writeFire = s_axi_awready;
  assign readFire = s_axi_arready;
  assign wAddr = s_axi_awaddr;

  // Stage 1 and stall decode
  logic s1Enabled;
  logic s1Performed;
  logic stallDisableEff;
  logic stallIllegal;

  assign s1Enabled = entry.configField[0];
  assign s1Performed = s1Enabled && !entry.defaultSubstreamBypass;
  // Absent stage 1 forces zero, disabled stage 1 ignores the bit
  assign stallDisableEff = caps.stage1PresentFlag && s1Enabled &&
    entry.stage1StallDisableBit;
  assign stallIllegal = stallDisableEff && (caps.stallModel != STALL_MODEL_CFG);

  // ATS field decode
  logic atsIgnored;
  logic silentRefuse;
  logic fullIllegal;
  logic splitIllegal;
  logic badEntry;
  logic [1:0] atsEff;

  assign atsIgnored = !caps.atsSupported || (entry.configField[1:0] == 2'h0);
  // A fully off entry or missing ATS refuses without recording events
  assign silentRefuse = !caps.atsSupported || (entry.configField == CFG_OFF);
  // Version dependent full ATS check
  assign fullIllegal = !atsIgnored && (entry.atsEnableField == ATS_FULL) &&
    entry.stage2StallSelect &&
    (v31Mode ? entry.configField[1] : (v30Strict || entry.configField[1]));
  assign splitIllegal = !atsIgnored && (entry.atsEnableField == ATS_SPLIT) &&
    ((entry.configField != CFG_NESTED) || entry.stage2StallSelect ||
     caps.splitStageUnsupportedFlag);
  assign badEntry = stallIllegal || fullIllegal || splitIllegal;

  // Effective ATS value seen by requests and translated traffic
  always_comb begin
    if (atsIgnored) begin
      atsEff = ATS_NONE;
    end else begin
      case (entry.atsEnableField)
        ATS_FULL: atsEff = ATS_FULL;
        ATS_SPLIT: atsEff = checkBit ? ATS_SPLIT : ATS_NONE;
        default: atsEff = ATS_NONE;
      endcase
    end
  end

  // Verdict for the current request
  verdict_t verdictNxt;
  always_comb begin
    verdictNxt = '0;
    verdictNxt.invalidEntry = badEntry;
    verdictNxt.partitionFromContext = s1Performed &&
      entry.stage1PartitionSourceSelect;
    verdictNxt.stallPermitted = !stallDisableEff;
    if (!badEntry) begin
      case (reqKind)
        XACT_TRANS_REQ: begin
          // Requests are always checked against the effective value
          case (atsEff)
            ATS_FULL: verdictNxt.serveFull = 1'b1;
            ATS_SPLIT: verdictNxt.serveStage1Only = 1'b1;
            default: begin
              verdictNxt.unsupportedRequest = 1'b1;
              verdictNxt.badTranslationRequestEvent = !silentRefuse;
            end
          endcase
        end
        XACT_TRANSLATED: begin
          if (!caps.atsSupported) begin
            verdictNxt.abortTranslated = 1'b1;
          end else if (!checkBit) begin
            verdictNxt.bypassTranslated = 1'b1;
          end else begin
            case (atsEff)
              ATS_FULL: verdictNxt.bypassTranslated = 1'b1;
              ATS_SPLIT: verdictNxt.translateStage2 = 1'b1;
              default: begin
                verdictNxt.abortTranslated = 1'b1;
                verdictNxt.translatedForbiddenEvent = !silentRefuse;
              end
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  // Registered verdict
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      verdict <= '0;
      verdictValid <= 1'b0;
    end else begin
      verdictValid <= reqValid;
      if (reqValid) begin
        verdict <= verdictNxt;
      end
    end
  end

  // Event capture for the status register
  logic [EVT_W-1:0] evtSet;
  always_comb begin
    evtSet = '0;
    evtSet[EVT_BAD_TREQ_BIT] = reqValid && verdictNxt.badTranslationRequestEvent;
    evtSet[EVT_FORBIDDEN_BIT] = reqValid && verdictNxt.translatedForbiddenEvent;
    evtSet[EVT_BAD_ENTRY_BIT] = reqValid && badEntry && (reqKind != XACT_UNTRANSLATED);
  end

  // Control register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (writeFire && wAddr == CTRL_OFF && s_axi_wstrb[0]) begin
      ctrl_r <= s_axi_wdata[2:0];
    end
  end

  // Mask register; its next value also feeds the interrupt so both move together
  logic [EVT_W-1:0] mask_nxt;
  assign mask_nxt = (writeFire && wAddr == MASK_OFF && s_axi_wstrb[0]) ?
    s_axi_wdata[EVT_W-1:0] : mask_r;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mask_r <= MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Sticky status, write one to clear, new event wins
  logic [EVT_W-1:0] clrBits;
  assign clrBits = (writeFire && wAddr == STATUS_OFF && s_axi_wstrb[0]) ?
    s_axi_wdata[EVT_W-1:0] : '0;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= (status_r & ~clrBits) | evtSet;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_r & ~clrBits) | evtSet) & mask_nxt);
    end
  end

  // Write channel: take address and data together, then respond
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (writeFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(wAddr) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one address at a time, data follows next cycle
  logic [31:0] rdMux;
  always_comb begin
    case (s_axi_araddr)
      CTRL_OFF: rdMux = {29'h0000_0000, ctrl_r};
      STATUS_OFF: rdMux = {29'h0000_0000, status_r};
      MASK_OFF: rdMux = {29'h0000_0000, mask_r};
      LAST_OFF: rdMux = {20'h0_0000, verdictValid, verdict};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (readFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_treq_off;
    reqValid && reqKind == XACT_TRANS_REQ && !badEntry && atsEff == ATS_NONE;
  endsequence

  sequence s_transl_checked_off;
    reqValid && reqKind == XACT_TRANSLATED && !badEntry && caps.atsSupported &&
      checkBit && atsEff == ATS_NONE;
  endsequence

  property p_partition_entry;
    reqValid && !s1Performed |=> !verdict.partitionFromContext;
  endproperty
  a_partition_entry: assert property (p_partition_entry)
    else $error("partition taken from context without stage 1");

  property p_stall_disable;
    reqValid && caps.stage1PresentFlag && s1Enabled && entry.stage1StallDisableBit
      |=> verdictValid && !verdict.stallPermitted;
  endproperty
  a_stall_disable: assert property (p_stall_disable)
    else $error("stall permitted despite stall disable");

  property p_stall_no_stage1;
    reqValid && (!caps.stage1PresentFlag || !s1Enabled) |=> verdict.stallPermitted;
  endproperty
  a_stall_no_stage1: assert property (p_stall_no_stage1)
    else $error("stall disable not ignored");

  property p_stall_illegal;
    reqValid && s1Enabled && caps.stage1PresentFlag && entry.stage1StallDisableBit &&
      caps.stallModel != STALL_MODEL_CFG |=> verdict.invalidEntry;
  endproperty
  a_stall_illegal: assert property (p_stall_illegal)
    else $error("illegal stall disable accepted");

  property p_treq_off;
    s_treq_off |=> verdict.unsupportedRequest && !verdict.serveFull &&
      verdict.badTranslationRequestEvent == $past(!silentRefuse);
  endproperty
  a_treq_off: assert property (p_treq_off)
    else $error("disabled ATS request not refused");

  property p_treq_event_status;
    s_treq_off ##0 !silentRefuse |=> status_r[EVT_BAD_TREQ_BIT] ##1 1'b1;
  endproperty
  a_treq_event_status: assert property (p_treq_event_status)
    else $error("bad request event not recorded");

  property p_transl_forbidden;
    s_transl_checked_off |=> verdict.abortTranslated && !verdict.bypassTranslated;
  endproperty
  a_transl_forbidden: assert property (p_transl_forbidden)
    else $error("translated traffic not aborted");

  property p_full_bypass;
    reqValid && reqKind == XACT_TRANSLATED && !badEntry && caps.atsSupported &&
      atsEff == ATS_FULL |=> verdict.bypassTranslated;
  endproperty
  a_full_bypass: assert property (p_full_bypass)
    else $error("full ATS translated traffic blocked");

  property p_v31_illegal;
    reqValid && v31Mode && caps.atsSupported && entry.configField[1] &&
      entry.atsEnableField == ATS_FULL && entry.stage2StallSelect |=> verdict.invalidEntry;
  endproperty
  a_v31_illegal: assert property (p_v31_illegal)
    else $error("full ATS with stage 2 stall accepted");

  property p_split_illegal;
    reqValid && !atsIgnored && entry.atsEnableField == ATS_SPLIT &&
      entry.configField != CFG_NESTED |=> verdict.invalidEntry;
  endproperty
  a_split_illegal: assert property (p_split_illegal)
    else $error("split ATS on non-nested entry accepted");

  property p_split_unchecked;
    reqValid && reqKind == XACT_TRANS_REQ && !badEntry && !checkBit &&
      entry.atsEnableField == ATS_SPLIT |=> verdict.unsupportedRequest;
  endproperty
  a_split_unchecked: assert property (p_split_unchecked)
    else $error("unchecked split ATS served request");

  property p_unchecked_bypass;
    reqValid && reqKind == XACT_TRANSLATED && !badEntry && caps.atsSupported &&
      !checkBit |=> verdict.bypassTranslated && !verdict.translatedForbiddenEvent;
  endproperty
  a_unchecked_bypass: assert property (p_unchecked_bypass)
    else $error("translated traffic checked with check bit clear");

  property p_no_ats;
    reqValid && !caps.atsSupported |=> !verdict.serveFull && !verdict.serveStage1Only &&
      !verdict.bypassTranslated && !verdict.translateStage2;
  endproperty
  a_no_ats: assert property (p_no_ats)
    else $error("ATS traffic passed without support");

  property p_irq_follow;
    irq == ((status_r & mask_r) != '0);
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt low with unmasked status");

endmodule // stream_entry_stall_ats_check

// ---- shared/ste_check_pkg.sv ----
// Constants, register map and carrier types for the stream entry stall/ATS checker.
// Assumes a single core clock domain and an AXI4-Lite register master.
package stream_check_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF = 8'h08;
  localparam logic [7:0] LAST_OFF = 8'h0C;

  // Control register fields
  localparam int CTRL_CHECK_BIT = 0;
  localparam int CTRL_V31_BIT = 1;
  localparam int CTRL_V30_STRICT_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  // Status and mask layout
  localparam int EVT_BAD_TREQ_BIT = 0;
  localparam int EVT_FORBIDDEN_BIT = 1;
  localparam int EVT_BAD_ENTRY_BIT = 2;
  localparam int EVT_W = 3;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // Entry encodings
  localparam logic [1:0] ATS_NONE = 2'h0;
  localparam logic [1:0] ATS_FULL = 2'h1;
  localparam logic [1:0] ATS_SPLIT = 2'h2;
  localparam logic [2:0] CFG_NESTED = 3'h7;
  localparam logic [2:0] CFG_OFF = 3'h0;
  localparam logic [1:0] STALL_MODEL_CFG = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    XACT_UNTRANSLATED = 2'b00,
    XACT_TRANS_REQ = 2'b01,
    XACT_TRANSLATED = 2'b10
  } xact_kind_t;

  // Entry fields relevant to this checker
  typedef struct packed {
    logic [2:0] configField;
    logic defaultSubstreamBypass;
    logic stage1PartitionSourceSelect;
    logic stage1StallDisableBit;
    logic [1:0] atsEnableField;
    logic stage2StallSelect;
  } entry_t;

  // Implementation capability flags
  typedef struct packed {
    logic stage1PresentFlag;
    logic atsSupported;
    logic splitStageUnsupportedFlag;
    logic [1:0] stallModel;
  } caps_t;

  // Verdict for one checked transaction
  typedef struct packed {
    logic invalidEntry;
    logic unsupportedRequest;
    logic abortTranslated;
    logic bypassTranslated;
    logic serveFull;
    logic serveStage1Only;
    logic translateStage2;
    logic partitionFromContext;
    logic stallPermitted;
    logic badTranslationRequestEvent;
    logic translatedForbiddenEvent;
  } verdict_t;

endpackage

// ---- verification/rc_model.sv ----
// Root complex stand-in that relays endpoint ATS traffic into the checker.
// Assumes the bench asks for one transfer at a time, synchronous to core_clk.
`timescale 1ns/1ps
module rc_model
  import stream_check_pkg::*;
(
  input wire logic core_clk,
  input wire logic send,
  input wire xact_kind_t sendKind,
  output logic reqValid,
  output xact_kind_t reqKind
);
  // One-cycle strobe per transfer; kind churns when idle so no stale value looks valid
  always @(posedge core_clk) begin
    reqValid <= send;
    reqKind <= send ? sendKind : xact_kind_t'(~reqKind);
  end
endmodule // rc_model

// ---- verification/tb_stream_entry_stall_ats_check.sv ----
// Self-checking bench for the stream entry stall and ATS checker.
// Assumes rc_model as requester and register access over AXI4-Lite.
`timescale 1ns/1ps
module tb_stream_entry_stall_ats_check
  import stream_check_pkg::*;
;
  localparam xact_kind_t TR = XACT_TRANS_REQ;
  localparam xact_kind_t TT = XACT_TRANSLATED;
  localparam xact_kind_t UT = XACT_UNTRANSLATED;
  localparam logic [10:0] MA = 11'h7F3;
  localparam caps_t CF = '{1'b1, 1'b1, 1'b0, 2'h0};
  logic core_clk, reset_n, send, reqValid, verdictValid, irq;
  xact_kind_t sendKind, reqKind;
  entry_t entry;
  caps_t caps;
  verdict_t verdict;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors = 0, checked = 0, cyc = 0;

  // Device under test and requester model
  stream_entry_stall_ats_check u_dut (
    .core_clk, .reset_n, .reqValid, .reqKind, .entry, .caps, .verdict, .verdictValid, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  rc_model u_rc (.core_clk, .send, .sendKind, .reqValid, .reqKind);

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Watchdog against a hung handshake
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end

  // Comparisons
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpV(input logic [10:0] exp, input logic [10:0] mask);
    checked++;
    if ((verdict & mask) !== exp) begin
      errors++;
      $display("BAD verdict expected %h seen %h", exp, verdict & mask);
    end
  endtask

  // Register bus cycles: hold each channel until its ready is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(resp), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp("rdata", exp, s_axi_rdata);
    cmp("rresp", 32'(resp), 32'(s_axi_rresp));
  endtask

  // One checked transaction; verdict lands one cycle after the strobe
  task automatic chk(input xact_kind_t k, input entry_t e, input caps_t c,
      input logic [10:0] exp, input logic [10:0] mask);
    @(posedge core_clk);
    send <= 1'b1;
    sendKind <= k;
    entry <= e;
    caps <= c;
    @(posedge core_clk);
    send <= 1'b0;
    @(posedge core_clk);
    #1;
    cmp("verdictValid", 1'b1, verdictValid);
    cmpV(exp, mask);
  endtask
  function automatic entry_t mk(logic [2:0] cfg, logic [1:0] ats, logic s2s, logic sd);
    return '{cfg, 1'b0, 1'b0, sd, ats, s2s};
  endfunction

  // Reset values and unmapped access
  task automatic t_regs();
    rd(CTRL_OFF, 32'h0000_0002, RESP_OKAY);
    rd(STATUS_OFF, 32'h0000_0000, RESP_OKAY);
    rd(MASK_OFF, 32'h0000_0000, RESP_OKAY);
    rd(8'h10, 32'h0000_0000, RESP_DECERR);
    wr(8'h10, 32'h0000_0007, RESP_DECERR);
  endtask

  // Event, mask, interrupt and write-one-to-clear
  task automatic t_irq();
    chk(TR, mk(3'h7, ATS_NONE, 1'b0, 1'b0), CF, 11'h202, MA);
    rd(STATUS_OFF, 32'h0000_0001, RESP_OKAY);
    rd(LAST_OFF, 32'h0000_0206, RESP_OKAY);
    cmp("irq masked", 1'b0, irq);
    wr(MASK_OFF, 32'h0000_0007, RESP_OKAY);
    rd(MASK_OFF, 32'h0000_0007, RESP_OKAY);
    cmp("irq", 1'b1, irq);
    wr(STATUS_OFF, 32'h0000_0001, RESP_OKAY);
    rd(STATUS_OFF, 32'h0000_0000, RESP_OKAY);
    cmp("irq cleared", 1'b0, irq);
    chk(TR, mk(3'h6, ATS_SPLIT, 1'b0, 1'b0), CF, 11'h400, MA);
    rd(STATUS_OFF, 32'h0000_0004, RESP_OKAY);
    wr(STATUS_OFF, 32'h0000_0004, RESP_OKAY);
  endtask

  // ATS off, reserved code and ignored field
  task automatic t_none();
    chk(TT, mk(3'h7, ATS_NONE, 1'b0, 1'b0), CF, 11'h080, MA);
    wr(CTRL_OFF, 32'h0000_0003, RESP_OKAY);
    chk(TT, mk(3'h7, ATS_NONE, 1'b0, 1'b0), CF, 11'h101, MA);
    chk(TR, mk(3'h7, 2'h3, 1'b0, 1'b0), CF, 11'h202, MA);
    chk(TT, mk(3'h7, 2'h3, 1'b0, 1'b0), CF, 11'h101, MA);
    chk(TR, mk(3'h4, ATS_FULL, 1'b0, 1'b0), CF, 11'h202, MA);
    chk(TR, mk(3'h0, ATS_FULL, 1'b0, 1'b0), CF, 11'h200, MA);
  endtask

  // Full ATS and the newer stage-2 stall check
  task automatic t_full();
    chk(TR, mk(3'h7, ATS_FULL, 1'b0, 1'b0), CF, 11'h040, MA);
    chk(TT, mk(3'h7, ATS_FULL, 1'b0, 1'b0), CF, 11'h080, MA);
    chk(TR, mk(3'h7, ATS_FULL, 1'b1, 1'b0), CF, 11'h400, MA);
    chk(TR, mk(3'h5, ATS_FULL, 1'b1, 1'b0), CF, 11'h040, MA);
  endtask

  // Split-stage ATS, its illegal cases and the unchecked fallback
  task automatic t_split();
    caps_t c;
    c = CF;
    chk(TR, mk(3'h7, ATS_SPLIT, 1'b0, 1'b0), CF, 11'h020, MA);
    chk(TT, mk(3'h7, ATS_SPLIT, 1'b0, 1'b0), CF, 11'h010, MA);
    chk(TR, mk(3'h5, ATS_SPLIT, 1'b0, 1'b0), CF, 11'h400, MA);
    chk(TR, mk(3'h7, ATS_SPLIT, 1'b1, 1'b0), CF, 11'h400, MA);
    c.splitStageUnsupportedFlag = 1'b1;
    chk(TR, mk(3'h7, ATS_SPLIT, 1'b0, 1'b0), c, 11'h400, MA);
    wr(CTRL_OFF, 32'h0000_0002, RESP_OKAY);
    chk(TR, mk(3'h7, ATS_SPLIT, 1'b0, 1'b0), CF, 11'h202, MA);
    chk(TT, mk(3'h7, ATS_SPLIT, 1'b0, 1'b0), CF, 11'h080, MA);
  endtask

  // No ATS support and the older stage-2 stall check
  task automatic t_old();
    caps_t c;
    c = CF;
    c.atsSupported = 1'b0;
    chk(TR, mk(3'h7, ATS_FULL, 1'b0, 1'b0), c, 11'h200, MA);
    chk(TT, mk(3'h7, ATS_FULL, 1'b0, 1'b0), c, 11'h100, MA);
    wr(CTRL_OFF, 32'h0000_0001, RESP_OKAY);
    chk(TR, mk(3'h7, ATS_FULL, 1'b1, 1'b0), CF, 11'h400, MA);
    chk(TR, mk(3'h5, ATS_FULL, 1'b1, 1'b0), CF, 11'h040, MA);
    wr(CTRL_OFF, 32'h0000_0005, RESP_OKAY);
    chk(TR, mk(3'h5, ATS_FULL, 1'b1, 1'b0), CF, 11'h400, MA);
  endtask

  // Stall disable and partition source
  task automatic t_stall();
    caps_t c;
    entry_t e;
    c = CF;
    chk(UT, mk(3'h5, ATS_NONE, 1'b0, 1'b0), CF, 11'h004, 11'h404);
    chk(UT, mk(3'h5, ATS_NONE, 1'b0, 1'b1), CF, 11'h000, 11'h404);
    c.stallModel = 2'h1;
    chk(UT, mk(3'h5, ATS_NONE, 1'b0, 1'b1), c, 11'h400, 11'h404);
    chk(UT, mk(3'h6, ATS_NONE, 1'b0, 1'b1), c, 11'h000, 11'h400);
    c.stage1PresentFlag = 1'b0;
    chk(UT, mk(3'h5, ATS_NONE, 1'b0, 1'b1), c, 11'h000, 11'h400);
    e = mk(3'h5, ATS_NONE, 1'b0, 1'b0);
    e.stage1PartitionSourceSelect = 1'b1;
    chk(UT, e, CF, 11'h008, 11'h008);
    e.defaultSubstreamBypass = 1'b1;
    chk(UT, e, CF, 11'h000, 11'h008);
    e.configField = 3'h6;
    chk(UT, e, CF, 11'h000, 11'h008);
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {reset_n, send, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    sendKind = UT;
    entry = '0;
    caps = CF;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_irq();
    t_none();
    t_full();
    t_split();
    t_old();
    t_stall();
    finish_test();
  end
endmodule // tb_stream_entry_stall_ats_check
